// ==== design/atg_consts.svh ====
`ifndef ATG_CONSTS_SVH
`define ATG_CONSTS_SVH

// Opcodes of the transfer group
`define ATG_OPC_CONV_LOW   10'h249
`define ATG_OPC_MEM_XOR    6'h2C
`define ATG_OPC_CLK_CTL    10'h252
`define ATG_OPC_PU_FIRST   10'h257
`define ATG_OPC_PU_SECOND  10'h25E
`define ATG_OPC_CONV_CTL1  10'h244
`define ATG_OPC_CONV_CTL2  10'h245
`define ATG_OPC_CONV_CTL3  10'h246

// Opcode fields
`define ATG_GRP_HI         9
`define ATG_GRP_LO         4
`define ATG_IMM_HI         3
`define ATG_LOW_CLEAR      2'h0

// Data memory
`define ATG_MEM_DEPTH      9'h180

// APB register offsets
`define ATG_OFS_CTRL       8'h00
`define ATG_OFS_ACC        8'h04
`define ATG_OFS_COLUMN     8'h08
`define ATG_OFS_DPTR       8'h0C
`define ATG_OFS_MADDR      8'h10
`define ATG_OFS_MDATA      8'h14
`define ATG_OFS_CARRY      8'h18
`define ATG_OFS_STATUS     8'h1C
`define ATG_OFS_COUNT      8'h20

// Field positions and reset values
`define ATG_CTRL_EN_BIT    0
`define ATG_CARRY_BIT      0
`define ATG_CTRL_EN_RST    1'h1
`define ATG_NIB_RST        4'h0
`define ATG_PTR_RST        9'h000
`define ATG_COUNT_RST      16'h0000
`define ATG_COUNT_STEP     16'h0001
`define ATG_WORD_ZERO      32'h00000000

`endif

// ==== design/atg_core.sv ====
// Behaviour
// - Converter-low read: result bits 1:0 into accumulator 3:2, low two bits cleared.
// - Memory load: accumulator from memory at data pointer; column XORed with immediate.
// - Memory load opcode is group 2C with a 4-bit immediate 0 to 15.
// - Clock-control read copies the clock control register into the accumulator.
// - Opcode 10'h257 copies the first pull-up control register into the accumulator.
// - Opcode 10'h25E copies the second pull-up control register into accumulator.
// - Three converter-control reads copy the first, second or third control register.
`timescale 1ns/1ns
`include "atg_consts.svh"
module atg_core
  import atg_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        instr_valid_in,
  input  wire logic [9:0]  instr_in,
  input  wire logic [9:0]  conv_result_in,
  input  wire logic [3:0]  clock_control_register_in,
  input  wire logic [3:0]  pullup_control_first_in,
  input  wire logic [3:0]  pullup_control_second_in,
  input  wire logic [3:0]  converter_control_first_in,
  input  wire logic [3:0]  converter_control_second_in,
  input  wire logic [3:0]  converter_control_third_in,
  output logic      [3:0]  acc_out,
  output logic      [3:0]  column_out,
  output logic      [8:0]  data_pointer_out,
  output logic             carry_flag_out,
  output logic             skip_out,
  output logic             exec_done_out
);

  atg_dec_if dif ();

  atg_nib_t    acc;
  atg_nib_t    next_acc;
  atg_nib_t    column;
  atg_nib_t    next_column;
  atg_ptr_t    dptr;
  atg_ptr_t    next_dptr;
  atg_ptr_t    maddr;
  atg_ptr_t    next_maddr;
  logic        carry;
  logic        next_carry;
  logic        en;
  logic        next_en;
  atg_nib_t    last_op;
  atg_nib_t    next_last_op;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic        pready;
  logic        next_pready;
  logic        pslverr;
  logic        next_pslverr;
  logic        done;
  logic        next_done;
  logic        skip;
  logic        next_skip;
  atg_nib_t    mem [0:`ATG_MEM_DEPTH-1];
  logic        mem_we;
  atg_nib_t    mem_rd;
  atg_nib_t    mdata_rd;
  logic        apb_wr;
  logic        exec;
  logic        hit;
  logic [1:0]  conv_low;
  atg_op_t     op;
  atg_nib_t    imm;

  assign dif.opcode = instr_in;
  assign op         = dif.op;
  assign imm        = dif.imm;
  assign conv_low   = conv_result_in[1:0];

  atg_decoder u_dec (
    .d (dif.dec)
  );

  // Out-of-range addresses read as zero rather than aliasing
  assign mem_rd   = (dptr < `ATG_MEM_DEPTH) ? mem[dptr] : `ATG_NIB_RST;
  assign mdata_rd = (maddr < `ATG_MEM_DEPTH) ? mem[maddr] : `ATG_NIB_RST;

  assign apb_wr = psel_in && penable_in && pready && pwrite_in;
  assign exec   = instr_valid_in && en && (op != ATG_OP_NONE);

  // APB slave: one wait state, answer registered
  always_comb begin
    next_pready  = psel_in && penable_in && !pready;
    next_prdata  = `ATG_WORD_ZERO;
    next_pslverr = 1'b0;
    hit          = 1'b1;
    case (paddr_in)
      `ATG_OFS_CTRL:   next_prdata = 32'(en);
      `ATG_OFS_ACC:    next_prdata = 32'(acc);
      `ATG_OFS_COLUMN: next_prdata = 32'(column);
      `ATG_OFS_DPTR:   next_prdata = 32'(dptr);
      `ATG_OFS_MADDR:  next_prdata = 32'(maddr);
      `ATG_OFS_MDATA:  next_prdata = 32'(mdata_rd);
      `ATG_OFS_CARRY:  next_prdata = 32'(carry);
      `ATG_OFS_STATUS: next_prdata = 32'(last_op);
      `ATG_OFS_COUNT:  next_prdata = 32'(count);
      default:         hit = 1'b0;
    endcase
    if (!next_pready) begin
      next_prdata = `ATG_WORD_ZERO;
    end else if (!hit) begin
      next_pslverr = 1'b1;
    end
  end

  // Register writes first, then the instruction overrides the same cycle
  always_comb begin
    next_acc     = acc;
    next_column  = column;
    next_dptr    = dptr;
    next_maddr   = maddr;
    next_carry   = carry;
    next_en      = en;
    next_last_op = last_op;
    next_count   = count;
    next_done    = exec;
    next_skip    = 1'b0;
    mem_we       = 1'b0;
    if (apb_wr) begin
      case (paddr_in)
        `ATG_OFS_CTRL:   next_en = pwdata_in[`ATG_CTRL_EN_BIT];
        `ATG_OFS_ACC:    next_acc = pwdata_in[3:0];
        `ATG_OFS_COLUMN: next_column = pwdata_in[3:0];
        `ATG_OFS_DPTR:   next_dptr = pwdata_in[8:0];
        `ATG_OFS_MADDR:  next_maddr = pwdata_in[8:0];
        `ATG_OFS_MDATA:  mem_we = (maddr < `ATG_MEM_DEPTH);
        `ATG_OFS_CARRY:  next_carry = pwdata_in[`ATG_CARRY_BIT];
        default:         mem_we = 1'b0;
      endcase
    end
    if (exec) begin
      next_last_op = op;
      next_count   = count + `ATG_COUNT_STEP;
      // Carry is never touched by this group
      case (op)
        ATG_OP_CONV_LOW:  next_acc = {conv_low, `ATG_LOW_CLEAR};
        ATG_OP_MEM_XOR: begin
          next_acc    = mem_rd;
          next_column = column ^ imm;
        end
        ATG_OP_CLK_CTL:   next_acc = clock_control_register_in;
        ATG_OP_PU_FIRST:  next_acc = pullup_control_first_in;
        ATG_OP_PU_SECOND: next_acc = pullup_control_second_in;
        ATG_OP_CONV_CTL1: next_acc = converter_control_first_in;
        ATG_OP_CONV_CTL2: next_acc = converter_control_second_in;
        ATG_OP_CONV_CTL3: next_acc = converter_control_third_in;
        default:          next_acc = acc;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem[maddr] <= pwdata_in[3:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      acc     <= `ATG_NIB_RST;
      column  <= `ATG_NIB_RST;
      dptr    <= `ATG_PTR_RST;
      maddr   <= `ATG_PTR_RST;
      carry   <= 1'b0;
      en      <= `ATG_CTRL_EN_RST;
      last_op <= `ATG_NIB_RST;
      count   <= `ATG_COUNT_RST;
      prdata  <= `ATG_WORD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      done    <= 1'b0;
      skip    <= 1'b0;
    end else begin
      acc     <= next_acc;
      column  <= next_column;
      dptr    <= next_dptr;
      maddr   <= next_maddr;
      carry   <= next_carry;
      en      <= next_en;
      last_op <= next_last_op;
      count   <= next_count;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      done    <= next_done;
      skip    <= next_skip;
    end
  end

  assign acc_out          = acc;
  assign column_out       = column;
  assign data_pointer_out = dptr;
  assign carry_flag_out   = carry;
  assign skip_out         = skip;
  assign exec_done_out    = done;
  assign prdata_out       = prdata;
  assign pready_out       = pready;
  assign pslverr_out      = pslverr;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  a_conv_low_pair: assert property (
    exec && op == ATG_OP_CONV_LOW |=> acc_out == {$past(conv_low), `ATG_LOW_CLEAR})
    else $error("converter low pair not placed in accumulator 3:2");

  a_mem_load_acc: assert property (
    exec && op == ATG_OP_MEM_XOR |=> acc_out == $past(mem_rd))
    else $error("accumulator not loaded from memory at data pointer");

  a_column_xor_imm: assert property (
    exec && op == ATG_OP_MEM_XOR |=> column_out == ($past(column) ^ $past(imm)))
    else $error("column not XORed with immediate");

  a_mem_xor_group: assert property (
    instr_valid_in && en && instr_in[`ATG_GRP_HI:`ATG_GRP_LO] == `ATG_OPC_MEM_XOR
      |=> column_out == ($past(column_out) ^ $past(instr_in[`ATG_IMM_HI:0])))
    else $error("group 2C immediate not applied to column");

  a_clock_ctl_read: assert property (
    exec && op == ATG_OP_CLK_CTL |=> acc_out == $past(clock_control_register_in))
    else $error("clock control not copied");

  a_pullup_first_read: assert property (
    instr_valid_in && en && instr_in == `ATG_OPC_PU_FIRST
      |=> acc_out == $past(pullup_control_first_in))
    else $error("first pull-up control not copied");

  a_pullup_second_read: assert property (
    instr_valid_in && en && instr_in == `ATG_OPC_PU_SECOND
      |=> acc_out == $past(pullup_control_second_in))
    else $error("second pull-up control not copied");

  a_conv_ctl_second: assert property (
    instr_valid_in && en && instr_in == `ATG_OPC_CONV_CTL2
      |=> acc_out == $past(converter_control_second_in))
    else $error("second converter control not copied");

  a_conv_ctl_third: assert property (
    exec && op == ATG_OP_CONV_CTL3 |=> acc_out == $past(converter_control_third_in))
    else $error("third converter control not copied");

  a_carry_kept: assert property (
    exec && !(apb_wr && paddr_in == `ATG_OFS_CARRY) |=> $stable(carry_flag_out))
    else $error("carry changed by transfer instruction");

  a_one_cycle_noskip: assert property (
    exec |=> exec_done_out && !skip_out ##1 !skip_out)
    else $error("transfer not done in one cycle or skip raised");

  a_column_untouched: assert property (
    exec && op != ATG_OP_MEM_XOR && !apb_wr |=> $stable(column_out))
    else $error("column changed by non-memory transfer");

  a_conv_ctl_first: assert property (
    exec && op == ATG_OP_CONV_CTL1 |=> acc_out == $past(converter_control_first_in))
    else $error("first converter control not copied");

  a_conv_low_opcode: assert property (
    instr_valid_in && en && instr_in == `ATG_OPC_CONV_LOW
      |=> acc_out == {$past(conv_result_in[1:0]), `ATG_LOW_CLEAR})
    else $error("converter low opcode did not load accumulator 3:2");

  a_clock_ctl_opcode: assert property (
    instr_valid_in && en && instr_in == `ATG_OPC_CLK_CTL
      |=> acc_out == $past(clock_control_register_in))
    else $error("clock control opcode did not load accumulator");

  a_apb_one_wait: assert property (
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("bus access not answered after one wait state");

  a_pready_pulse: assert property (
    pready_out |=> !pready_out)
    else $error("bus ready held longer than one cycle");

  a_err_with_ready: assert property (
    pslverr_out |-> pready_out)
    else $error("bus error raised without ready");

  a_read_zero_idle: assert property (
    !pready_out |-> prdata_out == `ATG_WORD_ZERO)
    else $error("read data not zero outside answer cycle");

  a_no_done_idle: assert property (
    !exec |=> !exec_done_out)
    else $error("done pulse without executed instruction");

endmodule

// ==== design/atg_dec_if.sv ====
`timescale 1ns/1ns
interface atg_dec_if;
  import atg_pkg::*;
  logic [9:0] opcode;
  atg_op_t    op;
  atg_nib_t   imm;
  modport core (output opcode, input op, input imm);
  modport dec (input opcode, output op, output imm);
endinterface

// ==== design/atg_decoder.sv ====
`timescale 1ns/1ns
`include "atg_consts.svh"
module atg_decoder
  import atg_pkg::*;
(
  atg_dec_if.dec d
);

  always_comb begin
    d.imm = d.opcode[`ATG_IMM_HI:0];
    d.op  = ATG_OP_NONE;
    if (d.opcode[`ATG_GRP_HI:`ATG_GRP_LO] == `ATG_OPC_MEM_XOR) begin
      // Low nibble is the immediate, any of 16 values
      d.op = ATG_OP_MEM_XOR;
    end else begin
      case (d.opcode)
        `ATG_OPC_CONV_LOW:  d.op = ATG_OP_CONV_LOW;
        `ATG_OPC_CLK_CTL:   d.op = ATG_OP_CLK_CTL;
        `ATG_OPC_PU_FIRST:  d.op = ATG_OP_PU_FIRST;
        `ATG_OPC_PU_SECOND: d.op = ATG_OP_PU_SECOND;
        `ATG_OPC_CONV_CTL1: d.op = ATG_OP_CONV_CTL1;
        `ATG_OPC_CONV_CTL2: d.op = ATG_OP_CONV_CTL2;
        `ATG_OPC_CONV_CTL3: d.op = ATG_OP_CONV_CTL3;
        default:            d.op = ATG_OP_NONE;
      endcase
    end
  end

endmodule

// ==== design/atg_pkg.sv ====
package atg_pkg;

  typedef enum logic [3:0] {
    ATG_OP_NONE      = 4'h0,
    ATG_OP_CONV_LOW  = 4'h1,
    ATG_OP_MEM_XOR   = 4'h2,
    ATG_OP_CLK_CTL   = 4'h3,
    ATG_OP_PU_FIRST  = 4'h4,
    ATG_OP_PU_SECOND = 4'h5,
    ATG_OP_CONV_CTL1 = 4'h6,
    ATG_OP_CONV_CTL2 = 4'h7,
    ATG_OP_CONV_CTL3 = 4'h8
  } atg_op_t;

  typedef logic [3:0] atg_nib_t;
  typedef logic [8:0] atg_ptr_t;

endpackage

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`include "atg_consts.svh"
module tb_top
  import atg_pkg::*;
;
  typedef struct {logic [9:0] op; logic [3:0] acc; atg_op_t code;} atg_row_t;
  logic        sys_clk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        er, instr_valid_in, carry_flag_out, skip_out, exec_done_out;
  logic [9:0]  instr_in, conv_result_in;
  logic [3:0]  clk_ctl, pu_first, pu_second, cc_first, cc_second, cc_third, acc_out, column_out, col;
  logic [8:0]  data_pointer_out;
  int          err_total, n_checks;
  atg_row_t    rows[7];

  atg_core DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .conv_result_in(conv_result_in), .clock_control_register_in(clk_ctl),
    .pullup_control_first_in(pu_first), .pullup_control_second_in(pu_second),
    .converter_control_first_in(cc_first), .converter_control_second_in(cc_second),
    .converter_control_third_in(cc_third), .acc_out(acc_out),
    .column_out(column_out), .data_pointer_out(data_pointer_out), .carry_flag_out(carry_flag_out),
    .skip_out(skip_out), .exec_done_out(exec_done_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge; a hang is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1);
    chk(32'(n), 32'h2, "bus wait states");
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_er);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
    chk({31'h0, er}, {31'h0, exp_er}, "bus error");
  endtask

  task automatic exec(input logic [9:0] op, input logic [3:0] ea, input logic ed, input logic ec);
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= op;
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    #1;
    chk({28'h0, acc_out}, {28'h0, ea}, "accumulator");
    chk({31'h0, exec_done_out}, {31'h0, ed}, "done pulse");
    chk({31'h0, carry_flag_out}, {31'h0, ec}, "carry");
    chk({31'h0, skip_out}, 32'h0, "skip");
  endtask

  initial begin
    err_total = 0;
    n_checks = 0;
    #20000;
    err_total++;
    give_verdict();
  end

  initial begin
    srst_in = 1'b1; psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0; paddr_in = 8'h00;
    pwdata_in = 32'h0; instr_valid_in = 1'b0; instr_in = 10'h000; conv_result_in = 10'h3FD;
    clk_ctl = 4'hA; pu_first = 4'h3; pu_second = 4'hC; cc_first = 4'h5; cc_second = 4'h6; cc_third = 4'h9;
    rows = '{'{`ATG_OPC_CONV_LOW, 4'h4, ATG_OP_CONV_LOW}, '{`ATG_OPC_CLK_CTL, 4'hA, ATG_OP_CLK_CTL},
      '{`ATG_OPC_PU_FIRST, 4'h3, ATG_OP_PU_FIRST}, '{`ATG_OPC_PU_SECOND, 4'hC, ATG_OP_PU_SECOND},
      '{`ATG_OPC_CONV_CTL1, 4'h5, ATG_OP_CONV_CTL1}, '{`ATG_OPC_CONV_CTL2, 4'h6, ATG_OP_CONV_CTL2},
      '{`ATG_OPC_CONV_CTL3, 4'h9, ATG_OP_CONV_CTL3}};
    repeat (8) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1;
    chk({acc_out, column_out, data_pointer_out, carry_flag_out, exec_done_out, pready_out}, 32'h0, "reset");
    rd_chk(`ATG_OFS_CTRL, 32'h1, 1'b0);
    apb(1'b1, `ATG_OFS_CARRY, 32'h1);
    foreach (rows[i]) begin
      exec(rows[i].op, rows[i].acc, 1'b1, 1'b1);
      rd_chk(`ATG_OFS_STATUS, 32'(rows[i].code), 1'b0);
    end
    // Top word of memory too, to catch a short depth
    apb(1'b1, `ATG_OFS_MADDR, 32'h5);
    apb(1'b1, `ATG_OFS_MDATA, 32'h7);
    apb(1'b1, `ATG_OFS_MADDR, 32'h17F);
    apb(1'b1, `ATG_OFS_MDATA, 32'hB);
    apb(1'b1, `ATG_OFS_DPTR, 32'h5);
    col = 4'h0;
    for (int j = 0; j < 16; j++) begin
      exec({6'h2C, 4'(j)}, 4'h7, 1'b1, 1'b1);
      col ^= 4'(j);
      chk({28'h0, column_out}, {28'h0, col}, "column");
    end
    chk({23'h0, data_pointer_out}, 32'h5, "pointer");
    apb(1'b1, `ATG_OFS_DPTR, 32'h17F);
    exec(10'h2C3, 4'hB, 1'b1, 1'b1);
    chk({28'h0, column_out}, {28'h0, col ^ 4'h3}, "column");
    rd_chk(`ATG_OFS_COUNT, 32'h18, 1'b0);
    exec(10'h2B5, 4'hB, 1'b0, 1'b1);
    apb(1'b1, `ATG_OFS_CTRL, 32'h0);
    exec(`ATG_OPC_PU_FIRST, 4'hB, 1'b0, 1'b1);
    apb(1'b1, `ATG_OFS_CTRL, 32'h1);
    exec(`ATG_OPC_PU_FIRST, 4'h3, 1'b1, 1'b1);
    rd_chk(8'h40, 32'h0, 1'b1);
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1;
    chk({acc_out, column_out, carry_flag_out}, 32'h0, "second reset");
    give_verdict();
  end
endmodule
